// File: rtl/csc_status_fields.sv
// Capability fields of the card status block, set up over APB
`timescale 1ns/1ns
module csc_status_fields (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire csc_pkg::csc_evt_s evt,
   output csc_pkg::csc_stat_s     stat
);

   logic [5:0]  erase_limit;
   logic [1:0]  erase_delay;
   logic [15:0] erase_cnt;
   logic [3:0]  grade;
   logic [3:0]  fau;
   logic [7:0]  tier;
   logic [9:0]  rec_size;
   logic [21:0] ptr;
   logic [3:0]  rio;
   logic [31:0] cap;
   logic [2:0]  rej;
   logic        wr_en;
   logic        map_hit;
   logic [31:0] next_rdata;
   logic        grade_ok;
   logic        fau_ok;
   logic        tier_ok;
   logic        size_ok;
   logic        rio_ok;
   logic        fit_ok;
   logic        cur_fit;
   logic [3:0]  w_grade;
   logic [3:0]  w_fau;
   logic [7:0]  w_tier;
   logic [9:0]  w_size;
   logic [3:0]  w_rio;
   logic [22:0] span;
   logic [22:0] unit_end;
   logic        in_unit;
   logic        hit_clear;
   logic [2:0]  rej_set;
   csc_pkg::csc_stat_s next_stat;

   // Access phase completes in the cycle after setup
   assign wr_en = psel && penable && pready && pwrite;

   assign w_grade = pwdata[3:0];
   assign w_fau   = pwdata[csc_pkg::BUS_FAU_LSB +: 4];
   assign w_tier  = pwdata[7:0];
   assign w_size  = pwdata[csc_pkg::REC_SIZE_LSB +: 10];
   assign w_rio   = pwdata[3:0];

   // Illegal codes are refused so the card never reports them
   assign grade_ok = (w_grade == csc_pkg::GRADE_LOW) ||
                     (w_grade == csc_pkg::GRADE_10)  ||
                     (w_grade == csc_pkg::GRADE_30);
   assign fau_ok   = (w_fau == csc_pkg::FAU_NONE) ||
                     (w_fau >= csc_pkg::FAU_FIRST);
   assign tier_ok  = (w_tier == csc_pkg::TIER_NONE) ||
                     (w_tier == csc_pkg::TIER_6)    ||
                     (w_tier == csc_pkg::TIER_10)   ||
                     (w_tier == csc_pkg::TIER_30)   ||
                     (w_tier == csc_pkg::TIER_60)   ||
                     (w_tier == csc_pkg::TIER_90);
   assign size_ok  = (w_size == '0) ||
                     (csc_pkg::seq_unit_mb(w_size) != 4'h0);
   assign rio_ok   = (w_rio <= csc_pkg::RIO_MAX);

   // Unit count check against card capacity in MB
   function automatic logic fits(input logic [9:0]  size_mb,
                                 input logic [31:0] c);
      logic [16:0] need;
      need = {7'h00, size_mb} * (c[csc_pkg::CAP_EXT_BIT] ?
                                 {10'h000, csc_pkg::MIN_UNITS_XC} :
                                 {10'h000, csc_pkg::MIN_UNITS_HC});
      return (size_mb == '0) || ({15'h0000, need} <= {1'b0, c[30:0]});
   endfunction

   assign fit_ok  = fits(w_size, cap);
   // Capacity may shrink later; the size is kept, the flag shows it
   assign cur_fit = fits(rec_size, cap);

   // Any hit inside the suspended unit; a zero size means one block
   assign span     = (rec_size == '0) ? 23'h000001 :
                     {12'h000, rec_size, 1'b0};
   assign unit_end = {1'b0, ptr} + span;
   assign in_unit  = (ptr != '0) &&
                     ({1'b0, evt.acc_unit} >= {1'b0, ptr}) &&
                     ({1'b0, evt.acc_unit} < unit_end);
   assign hit_clear = evt.set_free ||
                      ((evt.host_wr || evt.host_er) && in_unit);

   // Erase time fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_limit <= csc_pkg::RST_ERASE_LIM;
         erase_delay <= csc_pkg::RST_ERASE_DLY;
         erase_cnt   <= csc_pkg::RST_ERASE_CNT;
      end else if (wr_en && paddr == csc_pkg::OFF_ERASE) begin
         erase_limit <= pwdata[csc_pkg::ERASE_LIM_LSB +: 6];
         erase_delay <= pwdata[csc_pkg::ERASE_DLY_LSB +: 2];
         erase_cnt   <= pwdata[csc_pkg::ERASE_CNT_LSB +: 16];
      end
   end

   // Fast bus fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grade <= csc_pkg::RST_GRADE;
         fau   <= csc_pkg::RST_FAU;
      end else if (wr_en && paddr == csc_pkg::OFF_BUS &&
                   grade_ok && fau_ok) begin
         grade <= w_grade;
         fau   <= w_fau;
      end
   end

   // Recording fields, taken as a pair so tier and size agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tier     <= csc_pkg::RST_TIER;
         rec_size <= csc_pkg::RST_REC_SIZE;
      end else if (wr_en && paddr == csc_pkg::OFF_REC &&
                   tier_ok && size_ok && fit_ok) begin
         // Any listed size that fits is taken; smallest is firmware's pick
         tier     <= w_tier;
         rec_size <= w_size;
      end
   end

   // Random I/O tier
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rio <= csc_pkg::RST_RIO;
      end else if (wr_en && paddr == csc_pkg::OFF_RIO && rio_ok) begin
         rio <= w_rio;
      end
   end

   // Capacity and class
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap <= csc_pkg::RST_CAP;
      end else if (wr_en && paddr == csc_pkg::OFF_CAP) begin
         cap <= pwdata;
      end
   end

   // Suspended-unit pointer; a new suspend beats a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr <= csc_pkg::RST_PTR;
      end else if (evt.suspend && evt.susp_unit != '0) begin
         ptr <= evt.susp_unit;
      end else if (hit_clear) begin
         ptr <= csc_pkg::RST_PTR;
      end
   end

   // Sticky refusal flags, write one to clear; a new refusal wins
   assign rej_set[0] = wr_en && paddr == csc_pkg::OFF_BUS &&
                       !(grade_ok && fau_ok);
   assign rej_set[1] = wr_en && paddr == csc_pkg::OFF_REC &&
                       !(tier_ok && size_ok && fit_ok);
   assign rej_set[2] = wr_en && paddr == csc_pkg::OFF_RIO && !rio_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rej <= 3'h0;
      end else if (wr_en && paddr == csc_pkg::OFF_STAT) begin
         rej <= (rej & ~pwdata[csc_pkg::STAT_REJ_LSB +: 3]) | rej_set;
      end else begin
         rej <= rej | rej_set;
      end
   end

   // Status block image, rebuilt from held state only
   always_comb begin
      next_stat = '0;
      next_stat.erase_limit = (erase_cnt == '0) ? 6'h00 :
                              erase_limit;
      next_stat.erase_delay = (erase_cnt == '0) ? 2'h0 :
                              erase_delay;
      next_stat.fast_bus_perf_grade      = grade;
      next_stat.fast_bus_alloc_unit_size = fau;
      next_stat.rec_tier                 = tier;
      next_stat.recording_alloc_unit_mb  = rec_size;
      next_stat.suspended_unit_pointer   = ptr;
      next_stat.random_io_perf_tier      = rio;
   end

   // Host sees a flop copy; no host path writes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat <= '0;
      end else begin
         stat <= next_stat;
      end
   end

   // APB read mux and decode
   always_comb begin
      next_rdata = 32'h00000000;
      map_hit    = 1'b1;
      unique case (paddr)
         csc_pkg::OFF_ERASE: begin
            next_rdata[csc_pkg::ERASE_LIM_LSB +: 6]  = erase_limit;
            next_rdata[csc_pkg::ERASE_DLY_LSB +: 2]  = erase_delay;
            next_rdata[csc_pkg::ERASE_CNT_LSB +: 16] = erase_cnt;
         end
         csc_pkg::OFF_BUS: begin
            next_rdata[3:0] = grade;
            next_rdata[csc_pkg::BUS_FAU_LSB +: 4] = fau;
         end
         csc_pkg::OFF_REC: begin
            next_rdata[7:0] = tier;
            next_rdata[csc_pkg::REC_SIZE_LSB +: 10] = rec_size;
         end
         csc_pkg::OFF_RIO:  next_rdata[3:0] = rio;
         csc_pkg::OFF_CAP:  next_rdata = cap;
         csc_pkg::OFF_SUSP: next_rdata[21:0] = ptr;
         csc_pkg::OFF_STAT: begin
            next_rdata[3:0] = csc_pkg::seq_unit_mb(rec_size);
            next_rdata[csc_pkg::STAT_FIT_BIT] = cur_fit;
            next_rdata[csc_pkg::STAT_REJ_LSB +: 3] = rej;
         end
         default: map_hit = 1'b0;
      endcase
   end

   // No wait state: answer registered during the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h00000000 : next_rdata;
         pslverr <= !map_hit ||
                    (pwrite && paddr == csc_pkg::OFF_SUSP);
      end else begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic evt_any;
   assign evt_any = evt.suspend || evt.set_free || evt.host_wr ||
                    evt.host_er;

   a_limit_zero_cnt: assert property (
      erase_cnt == '0 |=> stat.erase_limit == 6'h00)
      else $error("Erase limit nonzero with zero unit count");

   a_grade_code: assert property (
      stat.fast_bus_perf_grade inside {4'h0, 4'h1, 4'h3})
      else $error("Reserved fast bus grade reported");

   a_fau_code: assert property (
      !(stat.fast_bus_alloc_unit_size inside {[4'h1:4'h6]}))
      else $error("Unused fast bus unit size reported");

   a_tier_code: assert property (
      stat.rec_tier inside {8'h00, 8'h06, 8'h0a, 8'h1e, 8'h3c,
                            8'h5a})
      else $error("Reserved recording tier reported");

   a_rec_au_valid: assert property (
      stat.recording_alloc_unit_mb != '0 |->
      csc_pkg::seq_unit_mb(stat.recording_alloc_unit_mb) != 4'h0)
      else $error("Unlisted recording unit size reported");

   a_rio_code: assert property (
      stat.random_io_perf_tier <= 4'h2)
      else $error("Reserved random I/O tier reported");

   a_susp_load: assert property (
      evt.suspend && evt.susp_unit != '0 |=> ##1
      stat.suspended_unit_pointer == $past(evt.susp_unit, 2))
      else $error("Suspend did not load pointer");

   a_susp_clear: assert property (
      evt.set_free && !evt.suspend |=> ##1
      stat.suspended_unit_pointer == '0)
      else $error("Set-free did not clear pointer");

   a_stat_stable: assert property (
      !wr_en && !evt_any ##1 !wr_en && !evt_any |=>
      $stable(stat))
      else $error("Status changed without a cause");

   a_apb_answer: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("APB answer not one cycle after setup");

   c_suspend_then_clear: cover property (
      evt.suspend && evt.susp_unit != '0 ##[1:20] hit_clear);
   c_rec_accept: cover property (
      wr_en && paddr == csc_pkg::OFF_REC && w_size != '0 &&
      tier_ok && size_ok && fit_ok);
   c_unmapped: cover property (pready && pslverr);
   c_bus_refused: cover property (rej_set[0]);
   c_clear_in_unit: cover property (
      (evt.host_wr || evt.host_er) && in_unit);

endmodule

// File: rtl/csc_pkg.sv
// Shared constants and types for the card capability status fields
package csc_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_ERASE = 8'h00;
   localparam logic [7:0] OFF_BUS   = 8'h04;
   localparam logic [7:0] OFF_REC   = 8'h08;
   localparam logic [7:0] OFF_RIO   = 8'h0c;
   localparam logic [7:0] OFF_CAP   = 8'h10;
   localparam logic [7:0] OFF_SUSP  = 8'h14;
   localparam logic [7:0] OFF_STAT  = 8'h18;

   // Field positions inside the registers
   localparam int ERASE_LIM_LSB = 0;
   localparam int ERASE_DLY_LSB = 6;
   localparam int ERASE_CNT_LSB = 16;
   localparam int BUS_FAU_LSB   = 4;
   localparam int REC_SIZE_LSB  = 8;
   localparam int CAP_EXT_BIT   = 31;
   localparam int STAT_FIT_BIT  = 8;
   localparam int STAT_REJ_LSB  = 16;

   // Reset values: every capability reads as not supported
   localparam logic [5:0]  RST_ERASE_LIM = 6'h00;
   localparam logic [1:0]  RST_ERASE_DLY = 2'h0;
   localparam logic [15:0] RST_ERASE_CNT = 16'h0000;
   localparam logic [3:0]  RST_GRADE     = 4'h0;
   localparam logic [3:0]  RST_FAU       = 4'h0;
   localparam logic [7:0]  RST_TIER      = 8'h00;
   localparam logic [9:0]  RST_REC_SIZE  = 10'h000;
   localparam logic [21:0] RST_PTR       = 22'h000000;
   localparam logic [3:0]  RST_RIO       = 4'h0;
   localparam logic [31:0] RST_CAP       = 32'h00000000;

   // Legal codes
   localparam logic [3:0] GRADE_LOW  = 4'h0;
   localparam logic [3:0] GRADE_10   = 4'h1;
   localparam logic [3:0] GRADE_30   = 4'h3;
   localparam logic [3:0] FAU_NONE   = 4'h0;
   localparam logic [3:0] FAU_FIRST  = 4'h7;
   localparam logic [7:0] TIER_NONE  = 8'h00;
   localparam logic [7:0] TIER_6     = 8'h06;
   localparam logic [7:0] TIER_10    = 8'h0a;
   localparam logic [7:0] TIER_30    = 8'h1e;
   localparam logic [7:0] TIER_60    = 8'h3c;
   localparam logic [7:0] TIER_90    = 8'h5a;
   localparam logic [3:0] RIO_MAX    = 4'h2;

   // Least unit counts per capacity class
   localparam logic [6:0] MIN_UNITS_HC = 7'd40;
   localparam logic [6:0] MIN_UNITS_XC = 7'd80;

   typedef struct packed {
      logic        suspend;
      logic        set_free;
      logic        host_wr;
      logic        host_er;
      logic [21:0] susp_unit;
      logic [21:0] acc_unit;
   } csc_evt_s;

   // Status block bits 407:336
   typedef struct packed {
      logic [5:0]  erase_limit;
      logic [1:0]  erase_delay;
      logic [3:0]  fast_bus_perf_grade;
      logic [3:0]  fast_bus_alloc_unit_size;
      logic [7:0]  rec_tier;
      logic [5:0]  rsv_a;
      logic [9:0]  recording_alloc_unit_mb;
      logic [21:0] suspended_unit_pointer;
      logic [5:0]  rsv_b;
      logic [3:0]  random_io_perf_tier;
   } csc_stat_s;

   // Sequential unit size in MB, zero for a size that is not listed
   function automatic logic [3:0] seq_unit_mb(input logic [9:0] size_mb);
      logic [3:0] r;
      r = 4'h0;
      case (size_mb)
         10'h015, 10'h01c, 10'h02a: r = 4'h7;
         10'h01b, 10'h024, 10'h02d, 10'h036: r = 4'h9;
         10'h01e, 10'h03c: r = 4'ha;
         10'h008, 10'h010, 10'h018, 10'h020, 10'h028, 10'h030,
         10'h038, 10'h040, 10'h048, 10'h050, 10'h060, 10'h070,
         10'h078, 10'h080, 10'h090, 10'h0a0, 10'h0c0, 10'h0d8,
         10'h0e0, 10'h0f0, 10'h100, 10'h120, 10'h140, 10'h180,
         10'h1b0, 10'h1c0, 10'h1e0, 10'h200: r = 4'h8;
         default: r = 4'h0;
      endcase
      return r;
   endfunction

endpackage

// File: verif/csc_host_model.sv
// Host-side model that interprets the capability fields
`timescale 1ns/1ns
module csc_host_model (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire csc_pkg::csc_stat_s stat,
   input  wire logic               fast_mode,
   input  wire logic [3:0]         ordinary_alloc_unit_size,
   output logic [3:0]              eff_grade,
   output logic [3:0]              eff_alloc_unit
);
   // Host samples the block once per cycle, like a status read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_grade <= 4'h0;
      end else if (stat.fast_bus_perf_grade inside {4'h0, 4'h1, 4'h3}) begin
         eff_grade <= stat.fast_bus_perf_grade;
      end else begin
         eff_grade <= 4'h3; // Future codes count as top grade
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_alloc_unit <= 4'h0;
      end else if (fast_mode && stat.fast_bus_perf_grade != 4'h0) begin
         eff_alloc_unit <= stat.fast_bus_alloc_unit_size;
      end else begin
         eff_alloc_unit <= ordinary_alloc_unit_size;
      end
   end
endmodule

// File: verif/csc_status_fields_tb_top.sv
// Testbench for the card capability status fields
`timescale 1ns/1ns
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin errors++; \
   $display("ERROR %s expected %h seen %h", n, x, g); end end
module csc_status_fields_tb_top;
   logic               pclk, presetn, psel, penable, pwrite, pready;
   logic               pslverr, fast_mode;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata;
   logic [3:0]         ord_unit, eff_grade, eff_unit;
   csc_pkg::csc_evt_s  evt;
   csc_pkg::csc_stat_s stat;
   int                 errors, tests_run;

   csc_status_fields u_csc_status_fields (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evt(evt), .stat(stat));
   csc_host_model u_csc_host_model (.pclk(pclk), .presetn(presetn),
      .stat(stat), .fast_mode(fast_mode),
      .ordinary_alloc_unit_size(ord_unit), .eff_grade(eff_grade),
      .eff_alloc_unit(eff_unit));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      `CHK("pready", 1'b1, pready)
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Two extra edges let the stat flop follow the write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      `CHK("write pslverr", 1'b0, e)
      repeat (2) @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK("read pslverr", 1'b0, e)
   endtask

   // Pointer reaches stat two edges after the pulse
   task automatic ev(input logic [3:0] k, input logic [21:0] load_unit,
                     input logic [21:0] hit_unit);
      @(posedge pclk);
      evt <= csc_pkg::csc_evt_s'({k, load_unit, hit_unit});
      @(posedge pclk);
      evt <= '0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic rec(input logic [9:0] mb, input logic [7:0] t);
      wr(csc_pkg::OFF_REC, {14'h0, mb, t});
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      $display("ERROR watchdog expected done seen hang");
      finish_test();
   end

   initial begin
      logic [31:0]        r;
      logic               e;
      logic [7:0]         x;
      csc_pkg::csc_stat_s s;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      evt = '0;
      fast_mode = 1'b0;
      ord_unit = 4'h9;
      errors = 0;
      tests_run = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK("stat reset", 72'h0, stat)
      for (int i = 0; i < 6; i++) begin
         rd(8'(i * 4), r);
         `CHK("register reset", 32'h0, r)
      end
      $display("test reset done");

      for (int d = 0; d < 4; d++) begin
         wr(csc_pkg::OFF_ERASE, {16'h0001, 8'h00, 2'(d), 6'h3f});
         `CHK("erase delay", 2'(d), stat[65:64])
         `CHK("erase limit", 6'h3f, stat.erase_limit)
      end
      wr(csc_pkg::OFF_ERASE, 32'h00010001);
      `CHK("erase limit one", 6'h01, stat.erase_limit)
      wr(csc_pkg::OFF_ERASE, 32'h000000ff);
      `CHK("limit no count", 6'h00, stat.erase_limit)
      `CHK("delay no count", 2'h0, stat.erase_delay)
      $display("test erase done");

      x = 8'h0;
      for (int g = 0; g < 16; g++) begin
         wr(csc_pkg::OFF_BUS, {24'h0, 4'h7, 4'(g)});
         if (g == 0 || g == 1 || g == 3) x = 8'(g);
         `CHK("grade", x[3:0], stat[63:60])
      end
      rd(csc_pkg::OFF_STAT, r);
      `CHK("refusal flag", 1'b1, r[18:16] != 3'h0)
      wr(csc_pkg::OFF_STAT, 32'h00070000);
      rd(csc_pkg::OFF_STAT, r);
      `CHK("refusal cleared", 3'h0, r[18:16])
      x = 8'h7;
      for (int f = 0; f < 16; f++) begin
         wr(csc_pkg::OFF_BUS, {24'h0, 4'(f), 4'h3});
         if (f == 0 || f >= 7) x = 8'(f);
         `CHK("bus unit size", x[3:0], stat[59:56])
      end
      rd(csc_pkg::OFF_BUS, r);
      `CHK("bus readback", 8'hf3, r[7:0])
      `CHK("host ord unit", 4'h9, eff_unit)
      fast_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("host grade", 4'h3, eff_grade)
      `CHK("host fast unit", 4'hf, eff_unit)
      $display("test bus done");

      wr(csc_pkg::OFF_CAP, 32'd840);
      rec(10'h015, 8'h06);
      `CHK("rec size", 10'h015, stat.recording_alloc_unit_mb)
      rd(csc_pkg::OFF_STAT, r);
      `CHK("seq unit 7", 4'h7, r[3:0])
      wr(csc_pkg::OFF_CAP, 32'd6399);
      rec(10'h0a0, 8'h06);
      `CHK("size 40 short", 10'h015, stat.recording_alloc_unit_mb)
      wr(csc_pkg::OFF_CAP, 32'd6400);
      rec(10'h0a0, 8'h06);
      `CHK("size 40 fits", 10'h0a0, stat.recording_alloc_unit_mb)
      rd(csc_pkg::OFF_STAT, r);
      `CHK("seq unit 8", 4'h8, r[3:0])
      `CHK("size fits flag", 1'b1, r[8])
      wr(csc_pkg::OFF_CAP, 32'h80000000 | 32'd12799);
      rec(10'h015, 8'h06);
      rec(10'h0a0, 8'h06);
      `CHK("size 80 short", 10'h015, stat.recording_alloc_unit_mb)
      wr(csc_pkg::OFF_CAP, 32'h80000000 | 32'd12800);
      rec(10'h0a0, 8'h06);
      `CHK("size 80 fits", 10'h0a0, stat.recording_alloc_unit_mb)
      wr(csc_pkg::OFF_CAP, 32'd6399);
      rd(csc_pkg::OFF_STAT, r);
      `CHK("size fits flag low", 1'b0, r[8])
      wr(csc_pkg::OFF_CAP, 32'h80000000 | 32'd12800);
      rec(10'h009, 8'h06);
      rec(10'h3ff, 8'h06);
      `CHK("size unlisted", 10'h0a0, stat.recording_alloc_unit_mb)
      x = 8'h06;
      for (int t = 0; t < 256; t++) begin
         rec(10'h0a0, 8'(t));
         if (8'(t) inside {8'h00, 8'h06, 8'h0a, 8'h1e, 8'h3c,
                           8'h5a}) begin
            x = 8'(t);
         end
         `CHK("rec tier", x, stat.rec_tier)
      end
      x = 8'h0;
      for (int q = 0; q < 16; q++) begin
         wr(csc_pkg::OFF_RIO, 32'(q));
         if (q <= 2) x = 8'(q);
         `CHK("rio tier", x[3:0], stat.random_io_perf_tier)
      end
      $display("test recording done");

      ev(4'h8, 22'h000100, 22'h0);
      `CHK("ptr load", 22'h000100, stat.suspended_unit_pointer)
      rd(csc_pkg::OFF_SUSP, r);
      `CHK("ptr reg", 32'h00000100, r)
      apb(1'b1, csc_pkg::OFF_SUSP, 32'h0, r, e);
      `CHK("ptr write err", 1'b1, e)
      apb(1'b0, 8'h1c, 32'h0, r, e);
      `CHK("unmapped err", 1'b1, e)
      ev(4'h2, 22'h0, 22'h000240);
      ev(4'h2, 22'h0, 22'h0000ff);
      `CHK("wr outside", 22'h000100, stat.suspended_unit_pointer)
      s = stat;
      repeat (20) @(posedge pclk);
      `CHK("stable", s, stat)
      ev(4'h2, 22'h0, 22'h00023f);
      `CHK("wr inside", 22'h0, stat.suspended_unit_pointer)
      ev(4'h8, 22'h0, 22'h0);
      `CHK("zero suspend", 22'h0, stat.suspended_unit_pointer)
      ev(4'h8, 22'h3fffff, 22'h0);
      ev(4'h1, 22'h0, 22'h3fffff);
      `CHK("erase inside", 22'h0, stat.suspended_unit_pointer)
      ev(4'h8, 22'h00002a, 22'h0);
      ev(4'h4, 22'h0, 22'h0);
      `CHK("set free", 22'h0, stat.suspended_unit_pointer)
      ev(4'hc, 22'h000055, 22'h0);
      `CHK("suspend wins", 22'h000055, stat.suspended_unit_pointer)
      $display("test suspend done");
      finish_test();
   end
endmodule
